// ---- smrid_buf.sv ----
// Small valid/ready buffer between the memory port and the output shifter
module smrid_buf #(
	parameter int W = 8,
	parameter int DEPTH = 2
)(
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic flush_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [W-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [W-1:0] out_data_o
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	// Storage and pointers
	logic [W-1:0] mem [DEPTH];
	logic [W-1:0] next_mem [DEPTH];
	logic [PW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
	logic [PW:0] count, next_count;
	logic next_in_ready;
	logic push, pop;

	assign out_valid_o = count != '0;
	assign out_data_o = mem[rd_ptr];

	// Next pointers, count and ready
	always_comb
	begin
		push = in_valid_i & in_ready_o;
		pop = out_valid_o & out_ready_i;
		next_mem = mem;
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		next_count = count;
		if (flush_i)
		begin
			// Drop everything on a frame edge
			next_wr_ptr = '0;
			next_rd_ptr = '0;
			next_count = '0;
		end
		else
		begin
			if (push)
			begin
				next_mem[wr_ptr] = in_data_i;
				next_wr_ptr = (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop)
				next_rd_ptr = (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			next_count = count + (PW + 1)'(push) - (PW + 1)'(pop);
		end
		// Ready is registered so it reaches the source from a flop
		next_in_ready = next_count != (PW + 1)'(DEPTH);
	end

	// Registers
	always_ff @(posedge core_clk_i)
	begin
		mem <= next_mem;
		if (!rst_n_i)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			in_ready_o <= 1'b1;
		end
		else
		begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
			in_ready_o <= next_in_ready;
		end
	end
endmodule

// ---- smrid_mm.sv ----
// Behavioural bus master that drives the serial pins in clock mode 0
module smrid_mm (
	input wire logic core_clk_i,
	input wire logic so_i,
	input wire logic so_oe_i,
	output logic cs_n_o = 1'b1, // Deselected when idle
	output logic sck_o = 1'b0, // Clock stands low between frames
	output logic si_o = 1'b0, // Data line idle low
	output logic pause_n_o = 1'b1 // Pause released when idle
);
	timeunit 1ns;
	timeprecision 1ps;
	logic last = 1'b0; // Last level seen on the data line
	// Wait a number of core cycles
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk_i);
	endtask
	// Select the device
	task automatic open_f();
		cs_n_o <= 1'b0;
		sck_o <= 1'b0;
		cyc(4);
	endtask
	// Deselect with the clock low
	task automatic close_f();
		sck_o <= 1'b0;
		cyc(4);
		cs_n_o <= 1'b1;
		cyc(8);
	endtask
	// One byte each way; counts bits where the device drove the line
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output int drv);
		drv = 0;
		for (int i = 7; i >= 0; i--)
		begin
			sck_o <= 1'b0; // Data changes after the fall
			si_o <= tx[i]; // Command and address MSB first
			cyc(4);
			sck_o <= 1'b1;
			cyc(4);
			last = so_oe_i ? so_i : ~last; // Released line shows no stale value
			rx[i] = last;
			drv += int'(so_oe_i);
		end
	endtask
	// Clock pulses with select left as it is
	task automatic pulses(input int n, output int drv);
		drv = 0;
		repeat (n)
		begin
			sck_o <= 1'b1;
			cyc(4);
			sck_o <= 1'b0;
			cyc(4);
			drv += int'(so_oe_i);
		end
	endtask
	// Freeze, toggle the clock, then resume
	task automatic hold(input int n, output int drv);
		sck_o <= 1'b0;
		cyc(4);
		pause_n_o <= 1'b0; // Pause moves only with the clock low
		cyc(4);
		pulses(n, drv);
		pause_n_o <= 1'b1; // Released with the clock low
		cyc(4);
	endtask
endmodule

// ---- smrid_pkg.sv ----
// Package with constants, command codes and carrier types of the serial memory block
package smrid_pkg;
	// Core clock period in nanoseconds
	localparam int CLK_PERIOD_NS = 20;
	// Wake recovery time in microseconds
	localparam int WAKE_RECOVERY_TIME_US = 400;
	// Wake recovery in core cycles, least time so rounded up
	localparam int WAKE_REC_CYC = (WAKE_RECOVERY_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Address range
	localparam logic [16:0] ADDR_TOP = 17'h1FFFF;
	localparam logic [16:0] ADDR_BASE = 17'h00000;
	// Command codes
	localparam logic [7:0] READ_CMD_DEFAULT = 8'h03;
	localparam logic [7:0] FAST_READ_CMD = 8'h0B;
	localparam logic [7:0] SLEEP_CMD = 8'hB9;
	localparam logic [7:0] IDENTITY_QUERY_CMD = 8'h9F;
	localparam logic [7:0] SERIAL_QUERY_CMD = 8'hC3;
	// Last byte indexes of each phase
	localparam logic [3:0] ADDR_LAST = 4'h2;
	localparam logic [3:0] ID_LAST = 4'h8;
	localparam logic [3:0] SN_LAST = 4'h7;
	// Last bit index within a byte
	localparam logic [2:0] BIT_LAST = 3'h7;
	// Customer field when none is assigned
	localparam logic [15:0] SN_CUST_DEFAULT = 16'h0000;
	// Check value generator
	localparam logic [7:0] CRC_POLY = 8'h07;
	localparam logic [7:0] CRC_INIT = 8'h00;
	// Byte sent when the memory has not delivered
	localparam logic [7:0] IDLE_FILL = 8'hFF;
	// Synchroniser reset: select high, clock low, data low, pause released
	localparam logic [3:0] PINS_RST = 4'h9;

	// Bus pins sampled together
	typedef struct packed {
		logic cs_n;
		logic sck;
		logic si;
		logic pause_n;
	} smrid_pins_t;

	// Memory read request
	typedef struct packed {
		logic rd;
		logic [16:0] addr;
	} smrid_memreq_t;

	// Check byte over seven bytes, first byte in the top bits
	function automatic logic [7:0] crc8_calc(input logic [55:0] d);
		logic [7:0] c;
		c = CRC_INIT;
		for (int i = 6; i >= 0; i--)
		begin
			c = c ^ d[i * 8 +: 8];
			for (int b = 0; b < 8; b++)
				c = c[7] ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
		end
		return c;
	endfunction
endpackage

// ---- smrid_sync.sv ----
// Two-flop synchroniser for pins from outside the core clock domain
module smrid_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
)(
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	// First stage, read only by the second
	logic [W-1:0] meta;

	// Two stages
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			meta <= RST_VAL;
			q_o <= RST_VAL;
		end
		else
		begin
			meta <= d_i;
			q_o <= meta;
		end
	end
endmodule

// ---- smrid_top.sv ----
// Device-side serial command logic: reads, identity, serial number, pause and sleep
// Function
// - Read command, 17-bit address, then data
// - Serial input ignored while data returns
// - Address advances per byte, wraps at top
// - Data bytes shifted out MSB first
// - Select rising ends read, output released
// - Fast read code also starts a read
// - Fast read adds one ignored byte
// - Pause low at clock low freezes transfer
// - Pause high at clock low resumes transfer
// - Sleep command then select rise sleeps
// - Asleep: clock, input ignored, output off
// - Select fall wakes, recovery keeps output off
// - Identity command returns maker then product
// - Six continuation bytes then maker byte
// - Product bytes pack family, density, sub, revision
// - Serial query returns eight-byte serial number
// - Customer, unique value, check byte layout
// - Unassigned customer field reads zero
// - Serial bytes highest first, check last
module smrid_top #(
	parameter logic [7:0] READ_CODE = smrid_pkg::READ_CMD_DEFAULT, // Plain read code
	parameter int WAKE_CYC = smrid_pkg::WAKE_REC_CYC, // Wake recovery cycles
	parameter logic [7:0] ID_CONT = 8'h5A, // Continuation byte, arbitrary value
	parameter logic [7:0] ID_MAKER = 8'hA5, // Maker byte, arbitrary value
	parameter logic [2:0] ID_FAMILY = 3'h2, // Family code, arbitrary value
	parameter logic [4:0] ID_DENSITY = 5'h03, // Density code, arbitrary value
	parameter logic [1:0] ID_SUB = 2'h1, // Sub code, arbitrary value
	parameter logic [2:0] ID_REV = 3'h1, // Revision, arbitrary value
	parameter logic [15:0] SN_CUSTOMER = smrid_pkg::SN_CUST_DEFAULT, // Customer field
	parameter logic [39:0] SN_UNIQUE = 40'h0123456789 // Unique value, arbitrary
)(
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic cs_n_i,
	input wire logic sck_i,
	input wire logic si_i,
	input wire logic pause_n_i,
	output logic so_o,
	output logic so_oe_o,
	output smrid_pkg::smrid_memreq_t mem_req_o,
	input wire logic mem_valid_i,
	input wire logic [7:0] mem_data_i,
	output logic mem_ready_o,
	output logic asleep_o
);
	localparam int RW = $clog2(WAKE_CYC + 1);
	localparam logic [RW-1:0] REC_LAST = RW'(WAKE_CYC - 1);
	// Identity response, first byte in the top bits
	localparam logic [71:0] ID_VEC = {{6{ID_CONT}}, ID_MAKER, ID_FAMILY, ID_DENSITY,
		ID_SUB, ID_REV, 3'h0};
	// Serial number with its check byte last
	localparam logic [55:0] SN_HEAD = {SN_CUSTOMER, SN_UNIQUE};
	localparam logic [63:0] SN_VEC = {SN_HEAD, smrid_pkg::crc8_calc(SN_HEAD)};

	// Transaction states
	typedef enum logic [3:0] {
		ST_IDLE, ST_CMD, ST_ADDR, ST_DUMMY, ST_DATA, ST_IGNORE, ST_SLEEP, ST_WAKE
	} smrid_state_t;

	smrid_pkg::smrid_pins_t pins_raw, pins; // Raw and synchronised pins
	smrid_state_t st, next_st; // Transaction state
	logic sck_q, cs_q; // Previous synchronised clock and select
	logic held, next_held; // Transfer paused
	logic [2:0] bit_cnt, next_bit_cnt; // Input bit index
	logic [3:0] byte_cnt, next_byte_cnt; // Address or table byte index
	logic [6:0] sh_in, next_sh_in; // Input shifter
	logic [7:0] cmd, next_cmd; // Command of this frame
	logic [16:0] addr, next_addr; // Next address to fetch
	logic [7:0] sh_out, next_sh_out; // Output shifter
	logic [2:0] obit, next_obit; // Output bit index
	logic drv, next_drv; // Output is being driven
	logic sleep_arm, next_sleep_arm; // Sleep command seen
	logic [RW-1:0] rec_cnt, next_rec_cnt; // Recovery counter
	logic next_so, next_so_oe, next_asleep;
	smrid_pkg::smrid_memreq_t next_req;
	logic sck_rise, sck_fall, cs_rise, cs_fall, rise_e, fall_e;
	logic [7:0] byte_in, ld_byte, buf_data;
	logic [16:0] addr_in, fetch_addr;
	logic is_read, do_fetch, pop, buf_valid, ld_msb;

	// Pins pass two flops before use
	assign pins_raw = '{cs_n: cs_n_i, sck: sck_i, si: si_i, pause_n: pause_n_i};
	smrid_sync #(.W(4), .RST_VAL(smrid_pkg::PINS_RST)) u_sync (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.d_i(pins_raw),
		.q_o(pins)
	);

	// Memory bytes wait here so a slow shifter loses none
	smrid_buf #(.W(8), .DEPTH(2)) u_buf (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.flush_i(cs_rise | cs_fall),
		.in_valid_i(mem_valid_i & is_read & (st == ST_DATA)),
		.in_ready_o(mem_ready_o),
		.in_data_i(mem_data_i),
		.out_valid_o(buf_valid),
		.out_ready_i(pop),
		.out_data_o(buf_data)
	);

	// Edges of the sampled link clock and select
	assign sck_rise = pins.sck & ~sck_q;
	assign sck_fall = ~pins.sck & sck_q;
	assign cs_rise = pins.cs_n & ~cs_q;
	assign cs_fall = ~pins.cs_n & cs_q;
	// Clock edges count only while selected and not paused
	assign rise_e = sck_rise & ~held & ~pins.cs_n;
	assign fall_e = sck_fall & ~held & ~pins.cs_n;
	assign byte_in = {sh_in, pins.si};
	assign addr_in = {addr[15:0], pins.si};
	assign is_read = (cmd == READ_CODE) || (cmd == smrid_pkg::FAST_READ_CMD);
	assign ld_msb = ld_byte[7];

	// Source of the next output byte
	always_comb
	begin
		if (is_read)
			ld_byte = buf_valid ? buf_data : smrid_pkg::IDLE_FILL;
		else if (cmd == smrid_pkg::IDENTITY_QUERY_CMD)
			ld_byte = ID_VEC[8 * (8 - int'(byte_cnt)) +: 8];
		else
			ld_byte = SN_VEC[8 * (7 - int'(byte_cnt)) +: 8];
	end

	// Next state of the transaction, shifters and counters
	always_comb
	begin
		next_st = st;
		next_held = held;
		next_bit_cnt = bit_cnt;
		next_byte_cnt = byte_cnt;
		next_sh_in = sh_in;
		next_cmd = cmd;
		next_addr = addr;
		next_sh_out = sh_out;
		next_obit = obit;
		next_drv = drv;
		next_sleep_arm = sleep_arm;
		next_rec_cnt = rec_cnt;
		next_so = so_o;
		next_req = '{rd: 1'b0, addr: mem_req_o.addr};
		do_fetch = 1'b0;
		fetch_addr = addr;
		pop = 1'b0;
		// Pause follows its pin only while the clock is low
		if (!pins.sck)
			next_held = !pins.pause_n;
		if (st == ST_SLEEP)
		begin
			// Only select is watched
			if (cs_fall)
			begin
				next_st = ST_WAKE;
				next_rec_cnt = '0;
			end
		end
		else if (st == ST_WAKE)
		begin
			// Recovery on the core clock; a frame in progress is ignored
			if (rec_cnt == REC_LAST)
				next_st = pins.cs_n ? ST_IDLE : ST_IGNORE;
			else
				next_rec_cnt = rec_cnt + 1'b1;
		end
		else if (cs_rise)
		begin
			// Frame end: stop output, maybe sleep
			next_st = sleep_arm ? ST_SLEEP : ST_IDLE;
			next_drv = 1'b0;
			next_sleep_arm = 1'b0;
		end
		else if (cs_fall)
		begin
			// Fresh command byte each frame
			next_st = ST_CMD;
			next_bit_cnt = '0;
			next_byte_cnt = '0;
			next_obit = '0;
			next_drv = 1'b0;
			next_cmd = '0;
		end
		else
		begin
			unique case (st)
				ST_CMD:
				begin
					if (rise_e)
					begin
						next_sh_in = byte_in[6:0];
						next_bit_cnt = bit_cnt + 1'b1;
						if (bit_cnt == smrid_pkg::BIT_LAST)
						begin
							next_cmd = byte_in;
							if (byte_in == READ_CODE || byte_in == smrid_pkg::FAST_READ_CMD)
								next_st = ST_ADDR;
							else if (byte_in == smrid_pkg::IDENTITY_QUERY_CMD ||
								byte_in == smrid_pkg::SERIAL_QUERY_CMD)
								next_st = ST_DATA;
							else
							begin
								// Unknown codes idle out the frame
								next_st = ST_IGNORE;
								next_sleep_arm = byte_in == smrid_pkg::SLEEP_CMD;
							end
						end
					end
				end
				ST_ADDR:
				begin
					// Three address bytes, low 17 bits kept
					if (rise_e)
					begin
						next_addr = addr_in;
						next_bit_cnt = bit_cnt + 1'b1;
						if (bit_cnt == smrid_pkg::BIT_LAST)
						begin
							next_byte_cnt = byte_cnt + 1'b1;
							if (byte_cnt == smrid_pkg::ADDR_LAST)
							begin
								if (cmd == smrid_pkg::FAST_READ_CMD)
									next_st = ST_DUMMY;
								else
								begin
									next_st = ST_DATA;
									do_fetch = 1'b1;
									fetch_addr = addr_in;
								end
							end
						end
					end
				end
				ST_DUMMY:
				begin
					// Eight ignored clocks before data
					if (rise_e)
					begin
						next_bit_cnt = bit_cnt + 1'b1;
						if (bit_cnt == smrid_pkg::BIT_LAST)
						begin
							next_st = ST_DATA;
							do_fetch = 1'b1;
						end
					end
				end
				ST_DATA:
				begin
					// Serial input not looked at here
					if (fall_e)
					begin
						next_obit = obit + 1'b1;
						if (obit == 3'h0)
						begin
							next_so = ld_byte[7];
							next_sh_out = {ld_byte[6:0], 1'b0};
							next_drv = 1'b1;
							if (is_read)
							begin
								pop = buf_valid;
								do_fetch = 1'b1;
							end
							else if (byte_cnt == ((cmd == smrid_pkg::IDENTITY_QUERY_CMD) ?
								smrid_pkg::ID_LAST : smrid_pkg::SN_LAST))
								next_byte_cnt = '0;
							else
								next_byte_cnt = byte_cnt + 1'b1;
						end
						else
						begin
							next_so = sh_out[7];
							next_sh_out = {sh_out[6:0], 1'b0};
						end
					end
				end
				default:
				begin
					// Idle and ignore wait for select
				end
			endcase
		end
		// Fetch one byte and advance with wrap
		if (do_fetch)
		begin
			next_req = '{rd: 1'b1, addr: fetch_addr};
			next_addr = (fetch_addr == smrid_pkg::ADDR_TOP) ? smrid_pkg::ADDR_BASE :
				fetch_addr + 17'h1;
		end
		next_so_oe = next_drv & ~next_held;
		next_asleep = (next_st == ST_SLEEP) || (next_st == ST_WAKE);
	end

	// Registers
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			st <= ST_IDLE;
			sck_q <= 1'b0;
			cs_q <= 1'b1;
			held <= 1'b0;
			bit_cnt <= '0;
			byte_cnt <= '0;
			sh_in <= '0;
			cmd <= '0;
			addr <= '0;
			sh_out <= '0;
			obit <= '0;
			drv <= 1'b0;
			sleep_arm <= 1'b0;
			rec_cnt <= '0;
			so_o <= 1'b0;
			so_oe_o <= 1'b0;
			mem_req_o <= '0;
			asleep_o <= 1'b0;
		end
		else
		begin
			st <= next_st;
			sck_q <= pins.sck;
			cs_q <= pins.cs_n;
			held <= next_held;
			bit_cnt <= next_bit_cnt;
			byte_cnt <= next_byte_cnt;
			sh_in <= next_sh_in;
			cmd <= next_cmd;
			addr <= next_addr;
			sh_out <= next_sh_out;
			obit <= next_obit;
			drv <= next_drv;
			sleep_arm <= next_sleep_arm;
			rec_cnt <= next_rec_cnt;
			so_o <= next_so;
			so_oe_o <= next_so_oe;
			mem_req_o <= next_req;
			asleep_o <= next_asleep;
		end
	end

	// Checks
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_addr_done;
		st == ST_ADDR && rise_e && byte_cnt == smrid_pkg::ADDR_LAST && bit_cnt == 3'h7;
	endsequence
	sequence s_frame_end;
		cs_rise && st != ST_SLEEP && st != ST_WAKE;
	endsequence

	a_read_fetch: assert property ((s_addr_done and cmd == READ_CODE) |=>
		mem_req_o.rd && mem_req_o.addr == $past(addr_in) && st == ST_DATA)
		else $error("read did not fetch start address");
	a_fast_dummy: assert property ((s_addr_done and cmd == smrid_pkg::FAST_READ_CMD) |=>
		st == ST_DUMMY && !mem_req_o.rd)
		else $error("fast read skipped dummy byte");
	a_data_hold: assert property (st == ST_DATA && !cs_rise && !cs_fall |=>
		st == ST_DATA && $stable(cmd))
		else $error("data phase disturbed by input");
	a_addr_wrap: assert property (do_fetch && fetch_addr == smrid_pkg::ADDR_TOP |=>
		addr == smrid_pkg::ADDR_BASE)
		else $error("address did not wrap");
	a_msb_first: assert property (st == ST_DATA && fall_e && obit == 3'h0 && !cs_rise |=>
		so_o == $past(ld_msb))
		else $error("byte not sent msb first");
	a_frame_release: assert property (s_frame_end |=> !so_oe_o && !drv)
		else $error("output driven after select rose");
	// Release cycle excluded: held drops there and the output comes back
	a_pause_freeze: assert property (held && next_held && !cs_rise && !cs_fall &&
		st != ST_WAKE |=>
		$stable(st) && $stable(bit_cnt) && $stable(obit) && !so_oe_o)
		else $error("paused transfer moved");
	a_sleep_entry: assert property ((s_frame_end and sleep_arm) |=>
		st == ST_SLEEP && asleep_o)
		else $error("sleep not entered");
	a_sleep_quiet: assert property (st == ST_SLEEP || st == ST_WAKE |-> !so_oe_o)
		else $error("output driven while asleep");
	a_wake_start: assert property (st == ST_SLEEP && cs_fall |=>
		st == ST_WAKE && rec_cnt == '0 ##1 st == ST_WAKE && !so_oe_o)
		else $error("wake recovery not started");
	a_cmd_fresh: assert property (cs_fall && st != ST_SLEEP && st != ST_WAKE |=>
		st == ST_CMD && bit_cnt == '0 && byte_cnt == '0)
		else $error("command decode not restarted");
endmodule

// ---- tb_serial_memory_read_id_sleep.sv ----
// Self-checking testbench of the serial memory command logic
module tb_serial_memory_read_id_sleep;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int T_WAKE = 400; // Shortened wake recovery
	localparam logic [7:0] T_CONT = 8'h3C; // Arbitrary value
	localparam logic [7:0] T_MAKER = 8'hC9; // Arbitrary value
	localparam logic [2:0] T_FAM = 3'h5; // Arbitrary value
	localparam logic [4:0] T_DEN = 5'h0A; // Arbitrary value
	localparam logic [1:0] T_SUB = 2'h2; // Arbitrary value
	localparam logic [2:0] T_REV = 3'h6; // Arbitrary value
	localparam logic [39:0] T_UNQ = 40'hB14E27D863; // Arbitrary value
	localparam logic [7:0] RD = smrid_pkg::READ_CMD_DEFAULT; // Plain read
	logic core_clk, rst_n, cs_n, sck, si, pause_n, so, so_oe, asleep, mem_ready;
	logic mem_valid = 1'b0; // Memory answer
	logic mem_off; // Memory answer disable
	logic [7:0] mem_data = 8'h00;
	smrid_pkg::smrid_memreq_t mem_req;
	int errors = 0;
	int n_checks = 0;
	smrid_top #(.WAKE_CYC(T_WAKE), .ID_CONT(T_CONT), .ID_MAKER(T_MAKER), .ID_FAMILY(T_FAM),
		.ID_DENSITY(T_DEN), .ID_SUB(T_SUB), .ID_REV(T_REV), .SN_UNIQUE(T_UNQ)) smrid_top_i (
		.core_clk_i(core_clk), .rst_n_i(rst_n), .cs_n_i(cs_n), .sck_i(sck), .si_i(si),
		.pause_n_i(pause_n), .so_o(so), .so_oe_o(so_oe), .mem_req_o(mem_req),
		.mem_valid_i(mem_valid), .mem_data_i(mem_data), .mem_ready_o(mem_ready),
		.asleep_o(asleep));
	smrid_mm smrid_mm_i (.core_clk_i(core_clk), .so_i(so), .so_oe_i(so_oe), .cs_n_o(cs_n),
		.sck_o(sck), .si_o(si), .pause_n_o(pause_n));
	// 50 MHz core clock
	initial
	begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	// Memory content derived from the address
	function automatic logic [7:0] mb(input logic [16:0] a);
		return a[7:0] ^ {a[16:14], 5'h00};
	endfunction
	// Bitwise check value, MSB first, polynomial 07, zero start
	function automatic logic [7:0] crc_ref(input logic [55:0] d);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 55; i >= 0; i--)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
		return c;
	endfunction
	// Memory answers a fetch one cycle later and holds until taken
	always @(posedge core_clk)
	begin
		if (mem_valid && mem_ready)
			mem_valid <= 1'b0;
		if (mem_req.rd === 1'b1 && mem_off === 1'b0)
		begin
			mem_valid <= 1'b1;
			mem_data <= mb(mem_req.addr);
		end
	end
	// Compare and count
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Receive one byte, junk on the input line, line driven throughout
	task automatic rx_byte(input string what, input logic [7:0] exp);
		logic [7:0] rx;
		int d;
		smrid_mm_i.xfer(8'h9F, rx, d);
		chk(what, 16'(rx), 16'(exp));
		chk("drive", 16'(d), 16'h0008);
	endtask
	// Command plus three address bytes
	task automatic hdr(input logic [7:0] cmd, input logic [16:0] a);
		logic [23:0] w;
		logic [7:0] rx;
		int d;
		w = {7'h00, a};
		smrid_mm_i.open_f();
		smrid_mm_i.xfer(cmd, rx, d);
		for (int k = 2; k >= 0; k--)
			smrid_mm_i.xfer(w[k * 8 +: 8], rx, d); // Address MSB first
	endtask
	// Read across the top address, then deselect
	task automatic t_read();
		hdr(RD, 17'h1FFFE);
		rx_byte("rd0", mb(17'h1FFFE));
		rx_byte("rd1", mb(17'h1FFFF));
		rx_byte("rd2", mb(17'h00000));
		smrid_mm_i.close_f();
		chk("so_oe_end", 16'(so_oe), 16'h0000);
	endtask
	// Padded read: dummy byte undriven, then data
	task automatic t_fast();
		logic [7:0] rx;
		int d;
		hdr(8'h0B, 17'h0A5A5);
		smrid_mm_i.xfer(8'h00, rx, d);
		chk("dummy_oe", 16'(d), 16'h0000);
		rx_byte("fr0", mb(17'h0A5A5));
		rx_byte("fr1", mb(17'h0A5A6));
		smrid_mm_i.close_f();
		chk("fast_end", 16'(so_oe), 16'h0000);
	endtask
	// Pause between bytes with clock toggling
	task automatic t_pause();
		int d;
		hdr(RD, 17'h00100);
		rx_byte("pz0", mb(17'h00100));
		smrid_mm_i.hold(3, d);
		chk("paused_oe", 16'(d), 16'h0000);
		rx_byte("pz1", mb(17'h00101));
		smrid_mm_i.close_f();
	endtask
	// Aborted frame, then identity readout and its repeat
	task automatic t_ident();
		logic [7:0] rx;
		int d;
		smrid_mm_i.open_f();
		smrid_mm_i.xfer(RD, rx, d);
		smrid_mm_i.xfer(8'h01, rx, d);
		smrid_mm_i.close_f();
		smrid_mm_i.open_f();
		smrid_mm_i.xfer(8'h9F, rx, d); // Fresh decode after abort
		for (int k = 0; k < 6; k++)
			rx_byte("id_cont", T_CONT);
		rx_byte("id_maker", T_MAKER);
		rx_byte("id_hi", {T_FAM, T_DEN});
		rx_byte("id_lo", {T_SUB, T_REV, 3'h0});
		rx_byte("id_again", T_CONT);
		smrid_mm_i.close_f();
	endtask
	// Serial number, highest byte first, check byte last
	task automatic t_serial();
		logic [55:0] sn;
		logic [7:0] rx;
		int d;
		sn = {16'h0000, T_UNQ}; // Unassigned customer field
		smrid_mm_i.open_f();
		smrid_mm_i.xfer(8'hC3, rx, d);
		for (int k = 6; k >= 0; k--)
			rx_byte("sn", sn[k * 8 +: 8]);
		rx_byte("sn_crc", crc_ref(sn));
		smrid_mm_i.close_f();
	endtask
	// Memory never answers: filler byte goes out
	task automatic t_late();
		mem_off <= 1'b1;
		hdr(RD, 17'h00020);
		rx_byte("late", smrid_pkg::IDLE_FILL);
		smrid_mm_i.close_f();
		mem_off <= 1'b0;
	endtask
	// Sleep, ignored clocks, throwaway wake frame, recovery
	task automatic t_sleep();
		logic [7:0] rx;
		int d;
		smrid_mm_i.open_f();
		smrid_mm_i.xfer(8'hB9, rx, d);
		smrid_mm_i.close_f();
		chk("asleep", 16'(asleep), 16'h0001);
		smrid_mm_i.pulses(3, d);
		chk("sleep_oe", 16'(d), 16'h0000);
		hdr(RD, 17'h00005); // Throwaway wake-up frame
		smrid_mm_i.xfer(8'h00, rx, d);
		chk("wake_oe", 16'(d), 16'h0000);
		smrid_mm_i.close_f();
		chk("recovering", 16'(asleep), 16'h0001);
		smrid_mm_i.cyc(T_WAKE);
		chk("awake", 16'(asleep), 16'h0000);
		hdr(RD, 17'h00005);
		rx_byte("wk0", mb(17'h00005));
		smrid_mm_i.close_f();
	endtask
	// Counts, verdict, end of run
	task automatic stop_test();
		$display("errors %0d n_checks %0d", errors, n_checks);
		if (errors == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Watchdog against a hang
	initial
	begin
		repeat (20000) @(posedge core_clk);
		errors++;
		$display("[ERR] watchdog expected done seen hang");
		stop_test();
	end
	// Reset, then the scenarios
	initial
	begin
		rst_n = 1'b0;
		mem_off = 1'b0;
		repeat (6) @(posedge core_clk);
		rst_n <= 1'b1;
		smrid_mm_i.cyc(4);
		chk("rst_oe", 16'(so_oe), 16'h0000);
		chk("rst_ready", 16'(mem_ready), 16'h0001);
		t_read();
		t_fast();
		t_pause();
		t_ident();
		t_serial();
		t_late();
		t_sleep();
		stop_test();
	end
endmodule
